// File: logic/dcos_fifo.sv
// Purpose: small synchronous fifo between peripheral byte source and memory writer
// Assumes: single clock, depth a power of two
// Notes: in_ready comes from a flop so the block output stays registered
`timescale 1ns/1ps
module dcos_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PTR_W = $clog2(DEPTH);

  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dcos_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0] cnt_r;
  logic [PTR_W:0] cnt_nxt;
  logic in_ready_r;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = i_in_valid && in_ready_r;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = in_ready_r;
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // storage; no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers, fill level and registered ready
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt != (PTR_W+1)'(DEPTH));
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    push |-> cnt_r < (PTR_W+1)'(DEPTH))
    else $error("fifo pushed while full");
endmodule

// File: logic/dcos_pkg.sv
// Purpose: shared constants and types for the dma channel offset/size block
// Assumes: 8-bit special-function register space, one system clock
// Notes: offsets 0xCC and 0xCE sit on the dma register page
package dcos_pkg;
  // special-function register addresses
  localparam logic [7:0] OFS_HIGH_ADDR = 8'hCC;
  localparam logic [7:0] SIZE_LOW_ADDR = 8'hCD;
  localparam logic [7:0] OFS_LOW_ADDR = 8'hCE;
  localparam logic [7:0] SIZE_HIGH_ADDR = 8'hCF;
  localparam logic [7:0] CHAN_SEL_ADDR = 8'hD0;
  // field layout
  localparam int OFS_W = 10;
  localparam int OFS_HIGH_LSB = 8;
  localparam int OFS_HIGH_W = 2;
  localparam int SIZE_W = 16;
  // values after reset and on unmapped reads
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // structural defaults
  localparam int DEF_CHANNELS = 4;
  localparam int DEF_FIFO_DEPTH = 8;
  localparam int DEF_ADDR_W = 16;
  localparam int DATA_W = 8;
  // memory write engine states
  typedef enum logic {DCOS_IDLE, DCOS_WRITE} dcos_state_t;
endpackage

// File: logic/dcos_top.sv
// Purpose: per-channel address offset and transfer size registers of a dma engine
// Assumes: peripherals and memory on the same clock; memory holds write until ready
// Notes: bytes from peripherals pass an 8-deep fifo before the memory write
// Functional notes
// - memory address is the channel base address plus its address offset
// - each byte moved on a channel advances its offset by one, unless software writes that offset in the same cycle
// - offset-high register bits 1:0 are offset bits 9:8
// - offset and size registers reach only the channel picked in channel select
// - size-low register bits 7:0 are the transfer count low byte
`timescale 1ns/1ps
module dcos_top
  import dcos_pkg::*;
#(
  parameter int NCH = DEF_CHANNELS,
  parameter int ADDR_W = DEF_ADDR_W,
  parameter int FIFO_DEPTH = DEF_FIFO_DEPTH
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  output logic [7:0] O_SFR_RDATA,
  input wire logic [NCH*ADDR_W-1:0] I_BASE_ADDR,
  input wire logic I_PERIPH_VALID,
  input wire logic [DATA_W-1:0] I_PERIPH_DATA,
  input wire logic [$clog2(NCH)-1:0] I_PERIPH_CHAN,
  output logic O_PERIPH_READY,
  output logic O_MEM_WE,
  output logic [ADDR_W-1:0] O_MEM_ADDR,
  output logic [DATA_W-1:0] O_MEM_WDATA,
  input wire logic I_MEM_READY,
  output logic [NCH-1:0] O_CHAN_DONE
);
  localparam int CH_W = $clog2(NCH);

  // a single channel would leave a zero-width channel index
  if (NCH < 2 || NCH > 256 || ADDR_W < OFS_W) begin : g_bad_param
    $error("dcos_top: NCH must be 2..256 and ADDR_W at least the offset width");
  end

  logic [CH_W-1:0] sel_r;
  logic [OFS_W-1:0] ofs_r [NCH];
  logic [SIZE_W-1:0] size_r [NCH];
  logic [SIZE_W-1:0] moved_r [NCH];
  logic [NCH-1:0] done_r;
  logic [7:0] rdata_r;
  dcos_state_t state_r;
  logic [CH_W-1:0] cur_ch_r;
  logic we_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic fifo_valid;
  logic fifo_pop;
  logic [CH_W+DATA_W-1:0] fifo_out;
  logic [CH_W-1:0] fifo_ch;
  logic [DATA_W-1:0] fifo_data;
  logic mem_done;
  logic [NCH-1:0] done_nxt;
  logic [ADDR_W-1:0] base_of_fifo_ch;
  logic sel_in_range;

  // the fifo stalls the peripheral when the memory side lags
  dcos_fifo #(
    .WIDTH(CH_W + DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_in_valid(I_PERIPH_VALID),
    .i_in_data({I_PERIPH_CHAN, I_PERIPH_DATA}),
    .o_in_ready(O_PERIPH_READY),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_out),
    .i_out_ready(fifo_pop)
  );

  assign fifo_ch = fifo_out[CH_W+DATA_W-1:DATA_W];
  assign fifo_data = fifo_out[DATA_W-1:0];
  // take one byte only while idle, so the offset is settled before reuse
  assign fifo_pop = fifo_valid && (state_r == DCOS_IDLE);
  assign mem_done = (state_r == DCOS_WRITE) && I_MEM_READY;
  assign base_of_fifo_ch = I_BASE_ADDR[fifo_ch*ADDR_W +: ADDR_W];
  assign sel_in_range = (32'(sel_r) < NCH);

  // channel select keeps only the low CH_W bits of the write; a kept value of NCH or more reaches no channel
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      sel_r <= REG_RESET[CH_W-1:0];
    end else if (I_SFR_WR && I_SFR_ADDR == CHAN_SEL_ADDR) begin
      sel_r <= I_SFR_WDATA[CH_W-1:0];
    end
  end

  // offsets: a software write beats a same-cycle increment, so setup is never lost
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      for (int c = 0; c < NCH; c++) begin
        ofs_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (I_SFR_WR && sel_r == CH_W'(c) && I_SFR_ADDR == OFS_LOW_ADDR) begin
          ofs_r[c][7:0] <= I_SFR_WDATA;
        end else if (I_SFR_WR && sel_r == CH_W'(c) && I_SFR_ADDR == OFS_HIGH_ADDR) begin
          ofs_r[c][OFS_HIGH_LSB +: OFS_HIGH_W] <= I_SFR_WDATA[OFS_HIGH_W-1:0];
        end else if (mem_done && cur_ch_r == CH_W'(c)) begin
          ofs_r[c] <= ofs_r[c] + 1'b1;
        end
      end
    end
  end

  // transfer counts per channel
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      for (int c = 0; c < NCH; c++) begin
        size_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (I_SFR_WR && sel_r == CH_W'(c) && I_SFR_ADDR == SIZE_LOW_ADDR) begin
          size_r[c][7:0] <= I_SFR_WDATA;
        end else if (I_SFR_WR && sel_r == CH_W'(c) && I_SFR_ADDR == SIZE_HIGH_ADDR) begin
          size_r[c][15:8] <= I_SFR_WDATA;
        end
      end
    end
  end

  // bytes moved since the count was last programmed
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      for (int c = 0; c < NCH; c++) begin
        moved_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (I_SFR_WR && sel_r == CH_W'(c) &&
            (I_SFR_ADDR == SIZE_LOW_ADDR || I_SFR_ADDR == SIZE_HIGH_ADDR)) begin
          moved_r[c] <= '0;
        end else if (mem_done && cur_ch_r == CH_W'(c)) begin
          moved_r[c] <= moved_r[c] + 1'b1;
        end
      end
    end
  end

  // a channel is done when its moved count reaches the programmed count
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      done_nxt[c] = (moved_r[c] == size_r[c]);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      done_r <= '1;
    end else begin
      done_r <= done_nxt;
    end
  end

  assign O_CHAN_DONE = done_r;

  // memory write engine; bytes for a finished channel are dropped
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      state_r <= DCOS_IDLE;
      cur_ch_r <= '0;
      we_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end else begin
      case (state_r)
        DCOS_IDLE: begin
          if (fifo_pop && !done_nxt[fifo_ch]) begin
            state_r <= DCOS_WRITE;
            cur_ch_r <= fifo_ch;
            we_r <= 1'b1;
            addr_r <= base_of_fifo_ch + ADDR_W'(ofs_r[fifo_ch]);
            wdata_r <= fifo_data;
          end
        end
        DCOS_WRITE: begin
          if (I_MEM_READY) begin
            state_r <= DCOS_IDLE;
            we_r <= 1'b0;
          end
        end
        default: begin
          state_r <= DCOS_IDLE;
          we_r <= 1'b0;
        end
      endcase
    end
  end

  assign O_MEM_WE = we_r;
  assign O_MEM_ADDR = addr_r;
  assign O_MEM_WDATA = wdata_r;

  // register reads answer one cycle later; reserved bits read zero
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      rdata_r <= REG_RESET;
    end else if (I_SFR_RD) begin
      rdata_r <= UNMAPPED_READ;
      if (I_SFR_ADDR == CHAN_SEL_ADDR) begin
        rdata_r <= 8'(sel_r);
      end else if (sel_in_range) begin
        case (I_SFR_ADDR)
          OFS_HIGH_ADDR: rdata_r <= 8'(ofs_r[sel_r][OFS_W-1:OFS_HIGH_LSB]);
          OFS_LOW_ADDR: rdata_r <= ofs_r[sel_r][7:0];
          SIZE_LOW_ADDR: rdata_r <= size_r[sel_r][7:0];
          SIZE_HIGH_ADDR: rdata_r <= size_r[sel_r][15:8];
          default: rdata_r <= UNMAPPED_READ;
        endcase
      end
    end
  end

  assign O_SFR_RDATA = rdata_r;

  // checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  logic [OFS_W-1:0] ofs_cur;
  logic [SIZE_W-1:0] size_sel;
  logic sw_ofs_wr;
  assign ofs_cur = ofs_r[cur_ch_r];
  assign size_sel = size_r[sel_r];
  assign sw_ofs_wr = I_SFR_WR && (I_SFR_ADDR == OFS_LOW_ADDR || I_SFR_ADDR == OFS_HIGH_ADDR);

  sequence s_start;
    fifo_pop && !done_nxt[fifo_ch];
  endsequence
  sequence s_wait;
    we_r && !I_MEM_READY;
  endsequence

  AST_ADDR_SUM: assert property ($rose(we_r) |->
    addr_r == I_BASE_ADDR[cur_ch_r*ADDR_W +: ADDR_W] + ADDR_W'(ofs_cur) || $past(sw_ofs_wr))
    else $error("memory address is not base plus offset");
  AST_OFS_INC: assert property (mem_done && !sw_ofs_wr |=>
    ofs_cur == $past(ofs_cur) + 1'b1)
    else $error("offset did not advance after a byte");
  AST_HIGH_RSVD: assert property (I_SFR_RD && I_SFR_ADDR == OFS_HIGH_ADDR |=>
    O_SFR_RDATA[7:2] == 6'h00)
    else $error("offset high reserved bits not zero");
  AST_SEL_ROUTE: assert property (I_SFR_WR && I_SFR_ADDR == SIZE_LOW_ADDR && sel_in_range |=>
    size_r[$past(sel_r)][7:0] == $past(I_SFR_WDATA))
    else $error("size write not routed to selected channel");
  AST_SIZE_READ: assert property (I_SFR_RD && I_SFR_ADDR == SIZE_LOW_ADDR && sel_in_range |=>
    O_SFR_RDATA == $past(size_sel[7:0]))
    else $error("size low read mismatch");
  AST_START: assert property (s_start |=> O_MEM_WE && O_MEM_WDATA == $past(fifo_data))
    else $error("live channel byte not written");
  AST_DROP: assert property (fifo_pop && done_nxt[fifo_ch] |=> !O_MEM_WE)
    else $error("byte written for a finished channel");
  AST_HOLD: assert property (s_wait |=> O_MEM_WE && $stable(O_MEM_ADDR) && $stable(O_MEM_WDATA))
    else $error("memory write dropped before ready");
endmodule

// File: testbench/dcos_mem_model.sv
// Purpose: memory side partner of the dma offset block, logs accepted bytes
// Assumes: a write is taken at an edge where request and ready are both high
// Notes: slow mode answers every other cycle; stall holds ready low
`timescale 1ns/1ps
module dcos_mem_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_stall,
  input wire logic i_slow,
  output logic o_ready
);
  logic phase_r;
  logic [15:0] addr_q[$];
  logic [7:0] data_q[$];
  // ready pattern from a flop so it only moves just after an edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end
  assign o_ready = !i_stall && (!i_slow || phase_r);
  // log every accepted byte for the bench to compare later
  always_ff @(posedge i_clk) begin
    if (i_rst_n && i_we && o_ready) begin
      addr_q.push_back(i_addr);
      data_q.push_back(i_wdata);
    end
  end
endmodule

// File: testbench/dcos_top_test.sv
// Purpose: self-checking bench for the dma channel offset and size block
// Assumes: default parameters, 16-bit addresses, four channels
// Notes: inputs move on the falling edge; memory partner can stall or be slow
`timescale 1ns/1ps
module dcos_top_test;
  import dcos_pkg::*;
  localparam logic [15:0] BASE1 = 16'h1000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic pv = 1'b0;
  logic [7:0] pdata = 8'h00;
  logic [1:0] pchan = 2'h0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [63:0] base = {16'h3000, 16'h2800, BASE1, 16'h2000};
  logic [7:0] sfr_rdata;
  logic [7:0] rd;
  logic pready;
  logic mem_we;
  logic mem_ready;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [3:0] done;
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  int k;
  always #10 clk = ~clk;
  dcos_top dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_SFR_ADDR(sfr_addr), .I_SFR_WDATA(sfr_wdata),
    .I_SFR_WR(sfr_wr), .I_SFR_RD(sfr_rd), .O_SFR_RDATA(sfr_rdata), .I_BASE_ADDR(base),
    .I_PERIPH_VALID(pv), .I_PERIPH_DATA(pdata), .I_PERIPH_CHAN(pchan),
    .O_PERIPH_READY(pready), .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr),
    .O_MEM_WDATA(mem_wdata), .I_MEM_READY(mem_ready), .O_CHAN_DONE(done));
  dcos_mem_model mem (.i_clk(clk), .i_rst_n(rst_n), .i_we(mem_we), .i_addr(mem_addr),
    .i_wdata(mem_wdata), .i_stall(stall), .i_slow(slow), .o_ready(mem_ready));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobe lowered at a falling edge, next access starts one edge later
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  // ready is a flop, so its value at the falling edge is what the next edge samples
  task automatic push(input logic [1:0] c, input logic [7:0] d);
    @(negedge clk);
    pchan = c;
    pdata = d;
    pv = 1'b1;
    for (k = 0; k < 200 && pready !== 1'b1; k++) @(negedge clk);
    // a stuck ready counts once; the run still ends in the closing report
    if (k == 200) n_mismatch++;
    @(negedge clk);
    pv = 1'b0;
  endtask
  // watchdog for any hang
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    sfr_read(OFS_HIGH_ADDR, rd);
    chk("offset high reset", rd, 8'h00);
    sfr_read(SIZE_LOW_ADDR, rd);
    chk("size low reset", rd, 8'h00);
    chk("done after reset", done, 4'hF);
    sfr_read(8'h55, rd);
    chk("unmapped read", rd, 8'h00);
    $display("test reset done");
    sfr_write(CHAN_SEL_ADDR, 8'h01);
    sfr_write(OFS_HIGH_ADDR, 8'h00);
    sfr_write(OFS_LOW_ADDR, 8'h00);
    sfr_write(OFS_HIGH_ADDR, 8'h03);
    sfr_write(OFS_LOW_ADDR, 8'hFC);
    sfr_write(SIZE_LOW_ADDR, 8'h0C);
    sfr_write(SIZE_HIGH_ADDR, 8'h00);
    sfr_read(OFS_HIGH_ADDR, rd);
    chk("offset high ch1", rd, 8'h03);
    sfr_read(SIZE_LOW_ADDR, rd);
    chk("size low ch1", rd, 8'h0C);
    chk("done ch1 armed", done, 4'hD);
    sfr_write(CHAN_SEL_ADDR, 8'h00);
    sfr_read(SIZE_LOW_ADDR, rd);
    chk("size low ch0", rd, 8'h00);
    $display("test registers done");
    // fill the fifo while memory stalls, until it refuses
    stall = 1'b1;
    pchan = 2'h1;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      pv = pready;
      pdata = 8'h20 + n[7:0];
      if (pready === 1'b1) n++;
    end
    @(negedge clk);
    pv = 1'b0;
    chk("fifo refuses", pready, 1'b0);
    // fifo depth plus the one byte held by the stalled write engine
    chk("fill count", 16'(n), 16'(DEF_FIFO_DEPTH + 1));
    chk("first addr", mem_addr, BASE1 + 16'h03FC);
    chk("held request", mem_we, 1'b1);
    stall = 1'b0;
    slow = 1'b1;
    for (; n < 14; n++) push(2'h1, 8'h20 + n[7:0]);
    push(2'h0, 8'hEE);
    for (k = 0; k < 400 && done[1] !== 1'b1; k++) @(negedge clk);
    if (k == 400) n_mismatch++;
    repeat (30) @(negedge clk);
    chk("write count", 16'(mem.addr_q.size()), 16'd12);
    for (k = 0; k < 12 && k < mem.addr_q.size(); k++) begin
      chk("mem addr", mem.addr_q[k], BASE1 + ((16'h03FC + 16'(k)) & 16'h03FF));
      chk("mem data", mem.data_q[k], 8'h20 + 8'(k));
    end
    chk("done all", done, 4'hF);
    sfr_write(CHAN_SEL_ADDR, 8'h01);
    sfr_read(OFS_HIGH_ADDR, rd);
    chk("offset high after", rd, 8'h00);
    sfr_read(OFS_LOW_ADDR, rd);
    chk("offset low after", rd, 8'h08);
    sfr_write(CHAN_SEL_ADDR, 8'h00);
    sfr_read(OFS_LOW_ADDR, rd);
    chk("offset ch0 kept", rd, 8'h00);
    sfr_write(CHAN_SEL_ADDR, 8'h02);
    sfr_write(SIZE_HIGH_ADDR, 8'h5A);
    sfr_read(SIZE_HIGH_ADDR, rd);
    chk("size high ch2", rd, 8'h5A);
    sfr_read(SIZE_LOW_ADDR, rd);
    chk("size low ch2", rd, 8'h00);
    sfr_read(CHAN_SEL_ADDR, rd);
    chk("channel select", rd, 8'h02);
    chk("done ch2 armed", done, 4'hB);
    $display("test transfer done");
    end_of_test();
  end
endmodule
